// *** design/mmc_map.svh ***
// Register indices, field positions, reset values and masks of the memory map control unit
// Notes on behaviour
// - RAM position accepts only its first write in normal and emulation modes.
// - Position writes steer address decoding one cycle after the write.
// - RAM position bits 7:3 give the top five bits of the RAM base.
// - RAM align bit clear places RAM low in its space, set places it high.
// - Register block position accepts only its first write in normal and emulation modes.
// - Register block spans 1K or 2K, on any 2K boundary below 32K.
// - Register block base is a fixed zero plus position bits 6:3.
// - This unit's registers sit at the register block base plus four times their index.
// - Two read-only size registers at 0x1C and 0x1D report sizing switches.
// - Page index register at 0x30 holds six bits; upper two read zero.
// - EEPROM position at 0x12 holds base bits 7:3 and map enable bit 0.
// - Control register at 0x13 holds stretch, upper-half-only and program enable.
// - Each core access selects RAM, EEPROM, program or registers, or external in expanded modes; an unmapped single-chip access selects nothing.
// - No pins: every port connects to logic inside the core.
// - Stretch adds 0 to 3 cycles on external accesses; none in single-chip modes.
// - EEPROM map enable is writable at any time in every mode.
// - With EEPROM enabled and a nonzero EEPROM size switch, EEPROM decodes at its five base bits; size switch 00 maps no EEPROM.
// - Program enable clear removes program memory from the map.
`ifndef MMC_MAP_SVH
`define MMC_MAP_SVH

`define IDX_RAM_POS 8'h10
`define IDX_REG_POS 8'h11
`define IDX_EE_POS 8'h12
`define IDX_CTRL 8'h13
`define IDX_TEST0 8'h14
`define IDX_TEST1 8'h17
`define IDX_SIZE0 8'h1C
`define IDX_SIZE1 8'h1D
`define IDX_PAGE 8'h30
`define IDX_PAGE_RSVD 8'h31

`define MASK_RAM_POS 8'hF9
`define MASK_REG_POS 8'h78
`define MASK_EE_POS 8'hF9
`define MASK_CTRL 8'h0F
`define MASK_PAGE 8'h3F
`define MASK_EE_BASE 8'hF8
`define MASK_EE_EN 8'h01

`define RST_RAM_POS 8'h08
`define RST_REG_POS 8'h00
`define RST_EE_POS 8'h10
`define RST_CTRL 8'h0D
`define RST_CTRL_TEST 8'h0C
`define RST_PAGE 8'h00

`define BASE_MSB 7
`define BASE_LSB 3
`define ALIGN_BIT 0
`define EE_EN_BIT 0
`define PROG_EN_BIT 0
`define PROG_UPPER_BIT 1
`define STRETCH_MSB 3
`define STRETCH_LSB 2

`define SPACE_2K_BITS 11
`define REG_1K_BITS 10

`endif

// *** design/mmc_pkg.sv ***
// Types and mode helpers shared by the memory map control unit
package mmc_pkg;

    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE = 3'b000,
        MODE_EMULATION_NARROW = 3'b001,
        MODE_SPECIAL_TEST = 3'b010,
        MODE_EMULATION_WIDE = 3'b011,
        MODE_NORMAL_SINGLE = 3'b100,
        MODE_NORMAL_NARROW = 3'b101,
        MODE_PERIPHERAL = 3'b110,
        MODE_NORMAL_WIDE = 3'b111
    } op_mode_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } core_req_t;

    typedef struct packed {
        logic regspace_size_switch;
        logic [1:0] eeprom_size_switch;
        logic [2:0] ram_size_switch;
        logic [1:0] progmem_size_switch;
        logic [1:0] page_space_switch;
    } size_sw_t;

    typedef struct packed {
        logic [4:0] ram_base;
        logic ram_top_align;
        logic [4:0] reg_base;
        logic [4:0] eeprom_base_bits;
        logic eeprom_map_enable;
        logic progmem_map_enable;
        logic progmem_upper_half_only;
        logic [1:0] external_stretch_sel;
    } map_cfg_t;

    typedef struct packed {
        logic ram;
        logic regs;
        logic eeprom;
        logic progmem;
        logic external;
    } mem_sel_t;

    typedef struct packed {
        mem_sel_t sel;
        logic [1:0] stretch;
        logic emulation_chip_select_n;
        logic external_chip_select_n;
    } decode_out_t;

    // Special modes lift the write-once restriction
    function automatic logic is_special(input op_mode_t m);
        return !m[2] && (m != MODE_EMULATION_NARROW) && (m != MODE_EMULATION_WIDE) || m == MODE_PERIPHERAL;
    endfunction : is_special

    function automatic logic is_expanded(input op_mode_t m);
        return m[0] || m == MODE_SPECIAL_TEST;
    endfunction : is_expanded

endpackage : mmc_pkg

// *** design/mem_decoder.sv ***
// Address decoder that turns a core address and the map setup into a resource select
`timescale 1ns/1ps
`include "mmc_map.svh"
module mem_decoder
    import mmc_pkg::*;
(
    input wire core_req_t req,
    input wire op_mode_t mode,
    input wire map_cfg_t cfg,
    input wire size_sw_t sizes,
    output decode_out_t dec
);

    wire [15:0] a = req.addr;
    wire [10:0] off2k = a[10:0];
    // Wide enough that the top switch codes clamp to 2K rather than overflow to zero
    wire [15:0] ram_bytes = 16'h0080 << sizes.ram_size_switch;
    wire [11:0] ram_size = (ram_bytes > 16'h0800) ? 12'h800 : ram_bytes[11:0];
    wire [11:0] ram_low_edge = 12'h800 - ram_size;
    wire [14:0] ee_bytes = {2'b00, 13'h0400} << sizes.eeprom_size_switch;
    wire ee_sized = sizes.eeprom_size_switch != 2'b00;
    wire [15:0] ee_base = {cfg.eeprom_base_bits, 11'h000};
    wire [16:0] ee_end = {1'b0, ee_base} + {2'b00, ee_bytes};
    wire reg_in_2k = a[15:11] == cfg.reg_base;
    wire reg_hit = reg_in_2k && (sizes.regspace_size_switch || !a[`REG_1K_BITS]);
    wire ram_in_2k = a[15:11] == cfg.ram_base;
    wire ram_pos = cfg.ram_top_align ? ({1'b0, off2k} >= ram_low_edge) : ({1'b0, off2k} < ram_size);
    wire ram_hit = ram_in_2k && ram_pos;
    wire ee_hit = cfg.eeprom_map_enable && ee_sized && a >= ee_base && {1'b0, a} < ee_end;
    wire lower_fixed = a[15:14] == 2'b01;
    wire prog_hit = cfg.progmem_map_enable && a[15:14] != 2'b00 && !(cfg.progmem_upper_half_only && lower_fixed);
    wire expanded = is_expanded(mode);

    // Registers win over RAM, RAM over EEPROM, EEPROM over program memory
    wire s_reg = req.valid && reg_hit;
    wire s_ram = req.valid && !reg_hit && ram_hit;
    wire s_ee = req.valid && !reg_hit && !ram_hit && ee_hit;
    wire s_prog = req.valid && !reg_hit && !ram_hit && !ee_hit && prog_hit;
    wire s_ext = req.valid && expanded && !reg_hit && !ram_hit && !ee_hit && !prog_hit;
    wire emu = mode == MODE_EMULATION_NARROW || mode == MODE_EMULATION_WIDE;

    assign dec.sel.regs = s_reg;
    assign dec.sel.ram = s_ram;
    assign dec.sel.eeprom = s_ee;
    assign dec.sel.progmem = s_prog;
    assign dec.sel.external = s_ext;
    assign dec.stretch = s_ext ? cfg.external_stretch_sel : 2'b00;
    assign dec.emulation_chip_select_n = !(emu && s_prog);
    assign dec.external_chip_select_n = !s_ext;

endmodule : mem_decoder

// *** design/memory_map_control_regs.sv ***
// Memory map control registers with an APB slave and registered core address decode
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "mmc_map.svh"
module memory_map_control_regs
    import mmc_pkg::*;
#(
    parameter bit EE_BASE_WRITE_ONCE = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire op_mode_t op_mode,
    input wire size_sw_t size_sw,
    input wire core_req_t core_req,
    output decode_out_t core_decode,
    output logic [5:0] page_index_bits,
    output map_cfg_t map_cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] ram_base_position;
    logic [7:0] register_block_position;
    logic [7:0] eeprom_base_position;
    logic [7:0] system_control_extra;
    logic [7:0] program_page_index;

    logic lock_ram;
    logic lock_reg;
    logic lock_ee;
    logic lock_ctrl;
    logic init_done;

    ////////////////////////////////////////////////////////////////////////////
    // APB address decode

    function automatic logic idx_hit(input logic [10:0] off, input logic [7:0] idx);
        return off == {1'b0, idx, 2'b00};
    endfunction : idx_hit

    wire [4:0] reg_base_now = {1'b0, register_block_position[6:3]};
    wire [10:0] poff = paddr[10:0];
    wire in_block = paddr[15:11] == reg_base_now;

    wire hit_ram = in_block && idx_hit(poff, `IDX_RAM_POS);
    wire hit_reg = in_block && idx_hit(poff, `IDX_REG_POS);
    wire hit_ee = in_block && idx_hit(poff, `IDX_EE_POS);
    wire hit_ctrl = in_block && idx_hit(poff, `IDX_CTRL);
    wire hit_size0 = in_block && idx_hit(poff, `IDX_SIZE0);
    wire hit_size1 = in_block && idx_hit(poff, `IDX_SIZE1);
    wire hit_page = in_block && idx_hit(poff, `IDX_PAGE);
    wire hit_rsvd_page = in_block && idx_hit(poff, `IDX_PAGE_RSVD);

    // The whole test window reads zero, so any word inside it is accepted
    wire [7:0] word_idx = poff[9:2];
    wire hit_test = in_block && !poff[10] && poff[1:0] == 2'b00 &&
                    word_idx >= `IDX_TEST0 && word_idx <= `IDX_TEST1;

    wire mapped = hit_ram || hit_reg || hit_ee || hit_ctrl || hit_size0 ||
                  hit_size1 || hit_page || hit_rsvd_page || hit_test;

    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire wr_ok = access_phase && pwrite && mapped;
    wire [7:0] wbyte = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Write permission

    wire special = is_special(op_mode);

    wire may_ram = special || !lock_ram;
    wire may_reg = special || !lock_reg;
    wire may_ee_base = special || !EE_BASE_WRITE_ONCE || !lock_ee;
    wire may_ctrl = special || !lock_ctrl;

    wire wr_ram = wr_ok && hit_ram && may_ram;
    wire wr_reg = wr_ok && hit_reg && may_reg;
    wire wr_ee = wr_ok && hit_ee;
    wire wr_ctrl = wr_ok && hit_ctrl && may_ctrl;
    wire wr_page = wr_ok && hit_page;

    ////////////////////////////////////////////////////////////////////////////
    // Next register values

    wire [7:0] next_ram = wbyte & `MASK_RAM_POS;
    wire [7:0] next_reg = wbyte & `MASK_REG_POS;
    wire [7:0] ee_base_kept = eeprom_base_position & `MASK_EE_BASE;
    wire [7:0] ee_base_new = wbyte & `MASK_EE_BASE;
    wire [7:0] ee_en_new = wbyte & `MASK_EE_EN;
    // Map enable always follows the write, the base only when allowed
    wire [7:0] next_ee = (may_ee_base ? ee_base_new : ee_base_kept) | ee_en_new;
    wire [7:0] next_ctrl = wbyte & `MASK_CTRL;
    wire [7:0] next_page = wbyte & `MASK_PAGE;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_base_position <= `RST_RAM_POS;
        end else if (wr_ram) begin
            ram_base_position <= next_ram;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            register_block_position <= `RST_REG_POS;
        end else if (wr_reg) begin
            register_block_position <= next_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eeprom_base_position <= `RST_EE_POS;
        end else if (wr_ee) begin
            eeprom_base_position <= next_ee;
        end
    end

    // Special test mode comes out of reset with program memory unmapped;
    // the mode is a level, so it is applied one clock after reset release
    wire [7:0] ctrl_start = (op_mode == MODE_SPECIAL_TEST) ? `RST_CTRL_TEST : `RST_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_control_extra <= `RST_CTRL;
        end else if (!init_done) begin
            system_control_extra <= ctrl_start;
        end else if (wr_ctrl) begin
            system_control_extra <= next_ctrl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_page_index <= `RST_PAGE;
        end else if (wr_page) begin
            program_page_index <= next_page;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write-once locks, set by the first write outside special modes

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ram <= 1'b0;
            lock_reg <= 1'b0;
            lock_ee <= 1'b0;
            lock_ctrl <= 1'b0;
        end else begin
            lock_ram <= lock_ram || (wr_ram && !special);
            lock_reg <= lock_reg || (wr_reg && !special);
            lock_ee <= lock_ee || (wr_ee && !special);
            lock_ctrl <= lock_ctrl || (wr_ctrl && !special);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Size registers mirror the integration switches at read time
    wire [7:0] size0 = {size_sw.regspace_size_switch, 1'b0, size_sw.eeprom_size_switch,
                        1'b0, size_sw.ram_size_switch};
    wire [7:0] size1 = {size_sw.progmem_size_switch, 4'h0, size_sw.page_space_switch};

    wire [7:0] rd_byte =
        hit_ram ? ram_base_position :
        hit_reg ? register_block_position :
        hit_ee ? eeprom_base_position :
        hit_ctrl ? system_control_extra :
        hit_size0 ? size0 :
        hit_size1 ? size1 :
        hit_page ? program_page_index :
        8'h00;

    // Read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            prdata <= (!pwrite && mapped) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign pready = 1'b1;
    assign pslverr = access_phase && !mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Active map setup, one cycle behind the registers

    map_cfg_t next_cfg;
    map_cfg_t cfg_q;

    assign next_cfg.ram_base = ram_base_position[`BASE_MSB:`BASE_LSB];
    assign next_cfg.ram_top_align = ram_base_position[`ALIGN_BIT];
    assign next_cfg.reg_base = reg_base_now;
    assign next_cfg.eeprom_base_bits = eeprom_base_position[`BASE_MSB:`BASE_LSB];
    assign next_cfg.eeprom_map_enable = eeprom_base_position[`EE_EN_BIT];
    assign next_cfg.progmem_map_enable = system_control_extra[`PROG_EN_BIT];
    assign next_cfg.progmem_upper_half_only = system_control_extra[`PROG_UPPER_BIT];
    assign next_cfg.external_stretch_sel = system_control_extra[`STRETCH_MSB:`STRETCH_LSB];

    // The extra stage keeps a position write from redirecting the access
    // that is running in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= next_cfg;
        end
    end

    assign map_cfg = cfg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Core access decode

    decode_out_t dec_now;

    mem_decoder u_dec (
        .req(core_req),
        .mode(op_mode),
        .cfg(cfg_q),
        .sizes(size_sw),
        .dec(dec_now)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_decode <= '{sel: '0, stretch: 2'b00,
                             emulation_chip_select_n: 1'b1, external_chip_select_n: 1'b1};
        end else begin
            core_decode <= dec_now;
        end
    end

    assign page_index_bits = program_page_index[5:0];

endmodule : memory_map_control_regs

// *** tb/memory_map_control_regs_checker.sv ***
// Concurrent checks on the ports of the memory map control unit
`timescale 1ns/1ps
module memory_map_control_regs_checker
    import mmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire op_mode_t op_mode,
    input wire size_sw_t size_sw,
    input wire core_req_t core_req,
    input wire decode_out_t core_decode,
    input wire logic [5:0] page_index_bits,
    input wire map_cfg_t map_cfg
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] up_cnt;
    // Map setup loads its reset values just after release; only later changes need a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_map_after_write: assert property (up_cnt == 3'h7 && $changed(map_cfg) |-> $past(psel && penable && pwrite, 2))
        else $error("map setup changed without a write two cycles before");
    chk_reg_base_low: assert property (map_cfg.reg_base[4] == 1'b0)
        else $error("register block base above 32K");
    chk_sel_needs_req: assert property ((|core_decode.sel) |-> $past(core_req.valid) && $onehot0(core_decode.sel))
        else $error("decode select without a single core request");
    chk_ext_mode_only: assert property (core_decode.sel.external |-> $past(op_mode) inside {3'b001, 3'b010, 3'b011, 3'b101, 3'b111})
        else $error("external select in a single chip mode");
    chk_stretch_ext_only: assert property (core_decode.sel.external || core_decode.stretch != 2'h0 |->
        core_decode.sel.external && core_decode.stretch == $past(map_cfg.external_stretch_sel))
        else $error("stretch value wrong for this access");
    chk_prog_enabled: assert property (core_decode.sel.progmem |-> $past(map_cfg.progmem_map_enable))
        else $error("program memory selected while removed");
    chk_ee_enabled: assert property (core_decode.sel.eeprom |-> $past(map_cfg.eeprom_map_enable))
        else $error("eeprom selected while disabled");
    chk_ram_base_match: assert property (core_decode.sel.ram |-> $past(core_req.addr[15:11]) == $past(map_cfg.ram_base))
        else $error("ram selected outside its base window");
    chk_regs_base_match: assert property (core_decode.sel.regs |-> $past(core_req.addr[15:11]) == $past(map_cfg.reg_base))
        else $error("registers selected outside their base window");
    chk_err_access_only: assert property (pslverr |-> psel && penable)
        else $error("error response outside an access phase");
    chk_upper_read_zero: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule : memory_map_control_regs_checker

// *** tb/core_bus_model.sv ***
// Behavioural core side: issues one address and collects its decode
`timescale 1ns/1ps
module core_bus_model
    import mmc_pkg::*;
(
    input wire logic pclk,
    output core_req_t core_req,
    input wire decode_out_t core_decode
);
    initial begin
        core_req = '{valid: 1'b0, addr: 16'h0000};
    end
    // Idle address is inverted so a stale address never passes for a live one
    task automatic access(input logic [15:0] a, output decode_out_t d);
        core_req <= '{valid: 1'b1, addr: a};
        @(posedge pclk);
        core_req <= '{valid: 1'b0, addr: ~a};
        #1;
        d = core_decode;
        @(posedge pclk);
    endtask : access
endmodule : core_bus_model

// *** tb/test_memory_map_control_regs.sv ***
// Self-checking bench for the memory map control unit
`timescale 1ns/1ps
`include "mmc_map.svh"
module test_memory_map_control_regs
    import mmc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    op_mode_t op_mode;
    size_sw_t size_sw;
    core_req_t core_req;
    decode_out_t core_decode;
    logic [5:0] page_index_bits;
    map_cfg_t map_cfg;
    logic [4:0] blk;
    int num_errors = 0;
    int cmp_count = 0;

    memory_map_control_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
        .size_sw(size_sw), .core_req(core_req), .core_decode(core_decode), .page_index_bits(page_index_bits),
        .map_cfg(map_cfg));
    core_bus_model core (.pclk(pclk), .core_req(core_req), .core_decode(core_decode));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000; pwdata = 32'h0;
        op_mode = MODE_NORMAL_SINGLE;
        size_sw = '{1'b1, 2'b01, 3'b101, 2'b10, 2'b11};
        blk = 5'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] radr(input logic [7:0] idx);
        return {blk, 11'h000} + {6'h00, idx, 2'b00};
    endfunction : radr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask : check
    task automatic do_reset(input op_mode_t m);
        presetn <= 1'b0;
        op_mode <= m;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        blk = 5'h00;
        repeat (2) @(posedge pclk);
    endtask : do_reset
    // Ends at the access edge with psel and penable dropped; callers let one edge pass before the next setup
    task automatic apb_raw(input logic w, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd,
                           output logic err);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb_raw
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb_raw(1'b1, radr(idx), {24'h0, d}, r, e);
        @(posedge pclk);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb_raw(1'b0, radr(idx), 32'h0, r, e);
        @(posedge pclk);
        check({e, r[30:0]}, {24'h0, exp});
    endtask : rd_chk
    task automatic err_chk(input logic [15:0] a);
        logic [31:0] r;
        logic e;
        apb_raw(1'b0, a, 32'h0, r, e);
        @(posedge pclk);
        check({e, r[30:0]}, 32'h80000000);
    endtask : err_chk
    task automatic dec_chk(input logic [15:0] a, input logic [6:0] exp);
        decode_out_t d;
        logic emu_n;
        emu_n = !(exp[3] && op_mode inside {MODE_EMULATION_NARROW, MODE_EMULATION_WIDE});
        core.access(a, d);
        check({23'h0, d.emulation_chip_select_n, d.external_chip_select_n, d.sel, d.stretch},
              {23'h0, emu_n, !exp[2], exp});
    endtask : dec_chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        logic [7:0] idx [10] = '{`IDX_RAM_POS, `IDX_REG_POS, `IDX_EE_POS, `IDX_CTRL, `IDX_TEST0, `IDX_TEST1,
                                 `IDX_SIZE0, `IDX_SIZE1, `IDX_PAGE, `IDX_PAGE_RSVD};
        logic [7:0] exp [10] = '{`RST_RAM_POS, `RST_REG_POS, `RST_EE_POS, `RST_CTRL, 8'h00, 8'h00, 8'h95, 8'h83,
                                 `RST_PAGE, 8'h00};
        do_reset(MODE_NORMAL_SINGLE);
        for (int i = 0; i < 10; i++) begin
            rd_chk(idx[i], exp[i]);
        end
        wr(`IDX_TEST0, 8'hFF);
        wr(`IDX_SIZE0, 8'h00);
        rd_chk(`IDX_TEST0, 8'h00);
        rd_chk(`IDX_SIZE0, 8'h95);
        wr(`IDX_PAGE, 8'hFF);
        rd_chk(`IDX_PAGE, 8'h3F);
        check({26'h0, page_index_bits}, 32'h3F);
        wr(`IDX_PAGE, 8'h2A);
        rd_chk(`IDX_PAGE, 8'h2A);
        wr(`IDX_CTRL, 8'hF6);
        rd_chk(`IDX_CTRL, 8'h06);
        err_chk(16'h1040);
        err_chk(16'h0041);
        $display("test_reset_values done");
    endtask : test_reset_values
    task automatic test_write_once();
        do_reset(MODE_NORMAL_NARROW);
        wr(`IDX_RAM_POS, 8'hFF);
        rd_chk(`IDX_RAM_POS, 8'hF9);
        wr(`IDX_RAM_POS, 8'h00);
        rd_chk(`IDX_RAM_POS, 8'hF9);
        wr(`IDX_EE_POS, 8'h01);
        wr(`IDX_EE_POS, 8'h18);
        rd_chk(`IDX_EE_POS, 8'h18);
        wr(`IDX_REG_POS, 8'h8F);
        blk = 5'h01;
        rd_chk(`IDX_REG_POS, 8'h08);
        wr(`IDX_REG_POS, 8'h78);
        rd_chk(`IDX_REG_POS, 8'h08);
        err_chk(16'h0044);
        do_reset(MODE_EMULATION_WIDE);
        dec_chk(16'h0FFF, 7'b10000_00);
        dec_chk(16'hC000, 7'b00010_00);
        wr(`IDX_RAM_POS, 8'h51);
        wr(`IDX_RAM_POS, 8'h00);
        rd_chk(`IDX_RAM_POS, 8'h51);
        $display("test_write_once done");
    endtask : test_write_once
    task automatic test_special();
        logic [31:0] r;
        logic e;
        do_reset(MODE_SPECIAL_SINGLE);
        apb_raw(1'b1, radr(`IDX_RAM_POS), 32'h31, r, e);
        #1;
        check({26'h0, map_cfg.ram_base, map_cfg.ram_top_align}, 32'h02);
        @(posedge pclk);
        #1;
        check({26'h0, map_cfg.ram_base, map_cfg.ram_top_align}, 32'h0D);
        @(posedge pclk);
        wr(`IDX_RAM_POS, 8'h20);
        rd_chk(`IDX_RAM_POS, 8'h20);
        wr(`IDX_REG_POS, 8'h08);
        blk = 5'h01;
        wr(`IDX_REG_POS, 8'h10);
        blk = 5'h02;
        rd_chk(`IDX_REG_POS, 8'h10);
        do_reset(MODE_SPECIAL_TEST);
        rd_chk(`IDX_CTRL, `RST_CTRL_TEST);
        do_reset(MODE_PERIPHERAL);
        wr(`IDX_RAM_POS, 8'h20);
        wr(`IDX_RAM_POS, 8'h41);
        rd_chk(`IDX_RAM_POS, 8'h41);
        dec_chk(16'h2000, 7'b00000_00);
        $display("test_special done");
    endtask : test_special
    task automatic test_decode();
        logic [15:0] a [6] = '{16'h0000, 16'h0400, 16'h0800, 16'h0880, 16'h1000, 16'h4000};
        logic [6:0] x [6] = '{7'b01000_00, 7'b00001_11, 7'b10000_00, 7'b00001_11, 7'b00001_11, 7'b00010_00};
        size_sw <= '{1'b0, 2'b01, 3'b000, 2'b10, 2'b11};
        do_reset(MODE_NORMAL_WIDE);
        for (int i = 0; i < 6; i++) begin
            dec_chk(a[i], x[i]);
        end
        wr(`IDX_EE_POS, 8'h11);
        wr(`IDX_RAM_POS, 8'h09);
        wr(`IDX_CTRL, 8'h04);
        dec_chk(16'h1000, 7'b00100_00);
        dec_chk(16'h0FFF, 7'b10000_00);
        dec_chk(16'h0800, 7'b00001_01);
        dec_chk(16'h4000, 7'b00001_01);
        size_sw <= '{1'b1, 2'b01, 3'b000, 2'b10, 2'b11};
        do_reset(MODE_NORMAL_SINGLE);
        dec_chk(16'h0400, 7'b01000_00);
        dec_chk(16'h2000, 7'b00000_00);
        wr(`IDX_CTRL, 8'h0F);
        dec_chk(16'h4000, 7'b00000_00);
        dec_chk(16'h8000, 7'b00010_00);
        $display("test_decode done");
    endtask : test_decode
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        @(posedge pclk);
        test_reset_values();
        test_write_once();
        test_special();
        test_decode();
        wrap_up();
    end
endmodule : test_memory_map_control_regs

bind memory_map_control_regs memory_map_control_regs_checker chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode(op_mode), .size_sw(size_sw), .core_req(core_req), .core_decode(core_decode),
    .page_index_bits(page_index_bits), .map_cfg(map_cfg));
